// file: rtl/energy_mode_consts.vh
// Constants for the waveform and active energy mode register bank.
// Assumes inclusion by bare name from the design files of this block.
`ifndef ENERGY_MODE_CONSTS_VH
`define ENERGY_MODE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indexes (byte address is four times the index)
`define IDX_WAV_MODE 8'h0C
`define IDX_WAT_MODE 8'h0D
`define IDX_FREQ_NUM 8'h10
`define IDX_IRQ_STAT 8'h11
`define IDX_IRQ_MASK 8'h12

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define WAV_MODE_RST 8'h00
`define WAT_MODE_RST 8'h3F
`define IRQ_MASK_RST 4'h0

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define WAV_SRC_LSB 0
`define WAV_RATE_LSB 3
`define WAV_SWAP_BIT 5
`define LWAT_SEL_LSB 0
`define WAT_SEL_LSB 3
`define WAT_FORM_LSB 6
`define NUM_NEG_LSB 12

////////////////////////////////////////////////////////////////////////////////
// Waveform sources and active formulas
`define SRC_VA 3'h0
`define SRC_VB 3'h1
`define SRC_VC 3'h2
`define SRC_IA 3'h3
`define SRC_IB 3'h4
`define SRC_IC 3'h5
`define FORM_SUM3 2'h0
`define FORM_AC_MB 2'h1
`define FORM_A_MB 2'h2

////////////////////////////////////////////////////////////////////////////////
// Timing: input clock / 3 / (128 << rate)
`define WAV_PRE_DIV 3
`define WAV_BASE_DIV 128

`endif

// file: rtl/wave_rate_div.v
// Waveform update rate divider: one-cycle tick every 3 * (128 << rate) clocks.
// Assumes one clock; rate is steady register state on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "energy_mode_consts.vh"

module wave_rate_div #(
    parameter PRE = `WAV_PRE_DIV,
    parameter BASE = `WAV_BASE_DIV
) (
    input wire clk,
    input wire rst,
    input wire [1:0] rate,
    output reg tick
);

    reg [1:0] pre_ff;
    reg [9:0] cnt_ff;
    wire pre_end;
    wire [10:0] limit;

    assign pre_end = (pre_ff == PRE[1:0] - 2'h1);
    assign limit = (BASE[10:0] << rate) - 11'h001;

    ////////////////////////////////////////////////////////////////////////////
    // Divide by three, then by the selected power of two
    always @(posedge clk) begin
        if (rst) begin
            pre_ff <= 2'h0;
            cnt_ff <= 10'h000;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            pre_ff <= pre_end ? 2'h0 : pre_ff + 2'h1;
            if (pre_end) begin
                if ({1'b0, cnt_ff} >= limit) begin
                    cnt_ff <= 10'h000;
                    tick <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 10'h001;
                end
            end
        end
    end

endmodule
`default_nettype wire

// file: rtl/active_terms.v
// Active energy formula terms from the per-phase voltage and current samples.
// Assumes signed samples; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "energy_mode_consts.vh"

module active_terms #(
    parameter W = 16
) (
    input wire signed [W-1:0] va,
    input wire signed [W-1:0] vb,
    input wire signed [W-1:0] vc,
    input wire signed [W-1:0] ia,
    input wire signed [W-1:0] ib,
    input wire signed [W-1:0] ic,
    input wire [1:0] formula,
    output reg signed [2*W:0] term_a,
    output reg signed [2*W:0] term_b,
    output reg signed [2*W:0] term_c
);

    wire signed [W:0] ia_mb;
    wire signed [W:0] ic_mb;
    wire signed [2*W:0] pa_mb;
    wire signed [2*W:0] pc_mb;
    wire signed [2*W:0] pa;
    wire signed [2*W:0] pb;
    wire signed [2*W:0] pc;

    assign ia_mb = ia - ib;
    assign ic_mb = ic - ib;
    assign pa_mb = va * ia_mb;
    assign pc_mb = vc * ic_mb;
    assign pa = va * ia;
    assign pb = vb * ib;
    assign pc = vc * ic;

    ////////////////////////////////////////////////////////////////////////////
    // Formula select; reserved code falls back to the plain sum
    always @* begin
        term_a = pa;
        term_b = pb;
        term_c = pc;
        case (formula)
            `FORM_AC_MB: begin
                term_a = pa_mb;
                term_b = {(2*W+1){1'b0}};
                term_c = pc_mb;
            end
            `FORM_A_MB: begin
                term_a = pa_mb;
                term_b = {(2*W+1){1'b0}};
            end
            default: begin
                term_a = pa;
            end
        endcase
    end

endmodule
`default_nettype wire

// file: rtl/energy_mode_bank.v
// Waveform and active energy mode register bank with APB register access.
// Assumes APB master on CLK_SYS; sample inputs come from logic on CLK_SYS.
//
// Function
// - Source field bits 0-2 picks VA VB VC IA IB IC; 6, 7 reserved
// - Rate field bits 3-4 sets update rate clock/3/128 up to /1024
// - Bit 5 swaps reactive into line active, line active into apparent
// - Watt mode bits 0-2 gate line active terms, bit 2 first
// - Watt mode bits 3-5 gate active terms, bit 5 first, reset ones
// - Same bits arm per-phase negative power flags in numerator bits 12-14
// - Second term is phase B product or zero per formula
// - Watt mode bits 6-7 choose the active energy formula
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "energy_mode_consts.vh"

module energy_mode_bank #(
    parameter SMP_W = 16,
    parameter ACC_W = 48
) (
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire SAMPLE_VALID,
    input wire signed [SMP_W-1:0] VA,
    input wire signed [SMP_W-1:0] VB,
    input wire signed [SMP_W-1:0] VC,
    input wire signed [SMP_W-1:0] IA,
    input wire signed [SMP_W-1:0] IB,
    input wire signed [SMP_W-1:0] IC,
    input wire signed [2*SMP_W:0] LINE_REACTIVE_INC,
    input wire signed [2*SMP_W:0] LINE_APPARENT_INC,
    output reg signed [SMP_W-1:0] WAVE_SAMPLE,
    output reg WAVE_VALID,
    output reg signed [ACC_W-1:0] ACTIVE_ENERGY,
    output reg signed [ACC_W-1:0] LINE_ACTIVE_ENERGY,
    output reg signed [ACC_W-1:0] LINE_APPARENT_ENERGY,
    output reg [2:0] NEG_POWER,
    output reg IRQ
);

    localparam TW = 2 * SMP_W + 1;
    localparam SW = TW + 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register index decode
    function is_reg;
        input [7:0] addr;
        input [7:0] idx;
        begin
            is_reg = (addr[1:0] == 2'h0) && (addr[7:2] == idx[5:0]);
        end
    endfunction

    // Sign extension of a power sum to accumulator width
    function [ACC_W-1:0] sext;
        input [SW-1:0] val;
        begin
            sext = {{(ACC_W-SW){val[SW-1]}}, val};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    reg [7:0] waveform_sampling_mode_ff;
    reg [7:0] active_energy_term_mode_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_mask_ff;
    reg [3:0] nxt_irq_stat;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    wire [2:0] nxt_neg;
    reg signed [SMP_W-1:0] nxt_wave;
    reg wave_src_ok;

    wire setup_cyc;
    wire access_done;
    wire wr_en;
    wire addr_ok;
    wire wave_tick;
    wire [2:0] waveform_source_select;
    wire [1:0] waveform_rate_select;
    wire line_reactive_swap_enable;
    wire [2:0] line_active_term_select;
    wire [2:0] active_term_select;
    wire [1:0] active_formula_select;
    wire [31:0] freq_output_numerator;
    wire signed [TW-1:0] term_a;
    wire signed [TW-1:0] term_b;
    wire signed [TW-1:0] term_c;
    wire signed [TW-1:0] terms [0:2];
    wire signed [SW-1:0] act_g [0:2];
    wire signed [SW-1:0] line_g [0:2];
    wire signed [SW-1:0] act_pwr;
    wire signed [SW-1:0] line_act_pwr;
    wire signed [SW-1:0] reactive_ext;
    wire signed [SW-1:0] apparent_ext;
    wire [3:0] irq_events;

    ////////////////////////////////////////////////////////////////////////////
    // Field views of the mode registers
    assign waveform_source_select = waveform_sampling_mode_ff[`WAV_SRC_LSB +: 3];
    assign waveform_rate_select = waveform_sampling_mode_ff[`WAV_RATE_LSB +: 2];
    assign line_reactive_swap_enable = waveform_sampling_mode_ff[`WAV_SWAP_BIT];
    assign line_active_term_select = active_energy_term_mode_ff[`LWAT_SEL_LSB +: 3];
    assign active_term_select = active_energy_term_mode_ff[`WAT_SEL_LSB +: 3];
    assign active_formula_select = active_energy_term_mode_ff[`WAT_FORM_LSB +: 2];
    assign freq_output_numerator = {17'h00000, NEG_POWER, 12'h000};

    ////////////////////////////////////////////////////////////////////////////
    // APB handshake decode
    assign setup_cyc = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && PREADY;
    assign wr_en = access_done && PWRITE && !PSLVERR;
    assign addr_ok = is_reg(PADDR, `IDX_WAV_MODE) || is_reg(PADDR, `IDX_WAT_MODE) ||
        is_reg(PADDR, `IDX_FREQ_NUM) || is_reg(PADDR, `IDX_IRQ_STAT) ||
        is_reg(PADDR, `IDX_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // Read data mux, captured in the setup cycle
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = !addr_ok;
        if (is_reg(PADDR, `IDX_WAV_MODE)) begin
            nxt_rdata = {24'h000000, waveform_sampling_mode_ff};
        end else if (is_reg(PADDR, `IDX_WAT_MODE)) begin
            nxt_rdata = {24'h000000, active_energy_term_mode_ff};
        end else if (is_reg(PADDR, `IDX_FREQ_NUM)) begin
            nxt_rdata = freq_output_numerator;
        end else if (is_reg(PADDR, `IDX_IRQ_STAT)) begin
            nxt_rdata = {28'h0000000, irq_stat_ff};
        end else if (is_reg(PADDR, `IDX_IRQ_MASK)) begin
            nxt_rdata = {28'h0000000, irq_mask_ff};
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else if (setup_cyc) begin
            PRDATA <= PWRITE ? 32'h00000000 : nxt_rdata;
            PREADY <= 1'b1;
            PSLVERR <= nxt_err;
        end else if (access_done) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode registers
    always @(posedge CLK_SYS) begin
        if (RST) begin
            waveform_sampling_mode_ff <= `WAV_MODE_RST;
            active_energy_term_mode_ff <= `WAT_MODE_RST;
            irq_mask_ff <= `IRQ_MASK_RST;
        end else if (wr_en) begin
            if (is_reg(PADDR, `IDX_WAV_MODE)) begin
                waveform_sampling_mode_ff <= PWDATA[7:0];
            end
            if (is_reg(PADDR, `IDX_WAT_MODE)) begin
                active_energy_term_mode_ff <= PWDATA[7:0];
            end
            if (is_reg(PADDR, `IDX_IRQ_MASK)) begin
                irq_mask_ff <= PWDATA[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Waveform sample path
    wave_rate_div u_rate (
        .clk(CLK_SYS),
        .rst(RST),
        .rate(waveform_rate_select),
        .tick(wave_tick)
    );

    always @* begin
        nxt_wave = {SMP_W{1'b0}};
        wave_src_ok = 1'b1;
        case (waveform_source_select)
            `SRC_VA: nxt_wave = VA;
            `SRC_VB: nxt_wave = VB;
            `SRC_VC: nxt_wave = VC;
            `SRC_IA: nxt_wave = IA;
            `SRC_IB: nxt_wave = IB;
            `SRC_IC: nxt_wave = IC;
            default: wave_src_ok = 1'b0;
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            WAVE_SAMPLE <= {SMP_W{1'b0}};
            WAVE_VALID <= 1'b0;
        end else begin
            WAVE_VALID <= wave_tick && wave_src_ok;
            if (!wave_src_ok) begin
                WAVE_SAMPLE <= {SMP_W{1'b0}};
            end else if (wave_tick) begin
                WAVE_SAMPLE <= nxt_wave;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Formula terms and per-term gating
    active_terms #(
        .W(SMP_W)
    ) u_terms (
        .va(VA),
        .vb(VB),
        .vc(VC),
        .ia(IA),
        .ib(IB),
        .ic(IC),
        .formula(active_formula_select),
        .term_a(term_a),
        .term_b(term_b),
        .term_c(term_c)
    );

    assign terms[0] = term_a;
    assign terms[1] = term_b;
    assign terms[2] = term_c;

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gate
            // Term g is selected by bit (2 - g) of each three-bit field
            assign act_g[g] = active_term_select[2-g] ?
                {{2{terms[g][TW-1]}}, terms[g]} : {SW{1'b0}};
            assign line_g[g] = line_active_term_select[2-g] ?
                {{2{terms[g][TW-1]}}, terms[g]} : {SW{1'b0}};
            assign nxt_neg[g] = active_term_select[2-g] && terms[g][TW-1];
        end
    endgenerate

    assign act_pwr = act_g[0] + act_g[1] + act_g[2];
    assign line_act_pwr = line_g[0] + line_g[1] + line_g[2];
    assign reactive_ext = {{2{LINE_REACTIVE_INC[TW-1]}}, LINE_REACTIVE_INC};
    assign apparent_ext = {{2{LINE_APPARENT_INC[TW-1]}}, LINE_APPARENT_INC};

    ////////////////////////////////////////////////////////////////////////////
    // Energy accumulation per input sample
    always @(posedge CLK_SYS) begin
        if (RST) begin
            ACTIVE_ENERGY <= {ACC_W{1'b0}};
            LINE_ACTIVE_ENERGY <= {ACC_W{1'b0}};
            LINE_APPARENT_ENERGY <= {ACC_W{1'b0}};
            NEG_POWER <= 3'h0;
        end else if (SAMPLE_VALID) begin
            ACTIVE_ENERGY <= ACTIVE_ENERGY + sext(act_pwr);
            NEG_POWER <= nxt_neg;
            if (line_reactive_swap_enable) begin
                LINE_ACTIVE_ENERGY <= LINE_ACTIVE_ENERGY + sext(reactive_ext);
                LINE_APPARENT_ENERGY <= LINE_APPARENT_ENERGY + sext(line_act_pwr);
            end else begin
                LINE_ACTIVE_ENERGY <= LINE_ACTIVE_ENERGY + sext(line_act_pwr);
                LINE_APPARENT_ENERGY <= LINE_APPARENT_ENERGY + sext(apparent_ext);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: bit 0 waveform ready, bits 1-3 negative power A B C
    assign irq_events = {SAMPLE_VALID ? nxt_neg : 3'h0, wave_tick && wave_src_ok};

    always @* begin
        nxt_irq_stat = irq_stat_ff;
        if (wr_en && is_reg(PADDR, `IDX_IRQ_STAT)) begin
            nxt_irq_stat = irq_stat_ff & ~PWDATA[3:0];
        end
        nxt_irq_stat = nxt_irq_stat | irq_events;
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            irq_stat_ff <= 4'h0;
            IRQ <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            IRQ <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

endmodule
`default_nettype wire

// file: verif/energy_mode_assertions.sv
// Checker for the mode register bank, bound to its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module energy_mode_checker #(
    parameter SMP_W = 16,
    parameter ACC_W = 48
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic SAMPLE_VALID,
    input wire logic signed [2*SMP_W:0] LINE_REACTIVE_INC,
    input wire logic signed [SMP_W-1:0] WAVE_SAMPLE,
    input wire logic WAVE_VALID,
    input wire logic signed [ACC_W-1:0] ACTIVE_ENERGY,
    input wire logic signed [ACC_W-1:0] LINE_ACTIVE_ENERGY,
    input wire logic [2:0] NEG_POWER,
    input wire logic IRQ
);
    logic [7:0] wav_ff;
    logic [7:0] wat_ff;
    logic mask_ff;
    wire wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    wire [2:0] sel3 = {wat_ff[3], wat_ff[4], wat_ff[5]};
    wire rsv = wav_ff[2:1] == 2'h3;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////
    // Shadow of mode and mask registers
    always @(posedge CLK_SYS) begin
        if (RST) begin
            wav_ff <= 8'h00;
            wat_ff <= 8'h3F;
            mask_ff <= 1'h0;
        end else if (wr_done) begin
            if (PADDR == 8'h30)
                wav_ff <= PWDATA[7:0];
            if (PADDR == 8'h34)
                wat_ff <= PWDATA[7:0];
            if (PADDR == 8'h48)
                mask_ff <= PWDATA[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ready_next_a: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no ready after setup");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data outside access");
    rsv_zero_a: assert property (rsv && $past(rsv) |-> WAVE_SAMPLE == 0 && !WAVE_VALID)
        else $error("reserved source not held at zero");
    valid_pulse_a: assert property (WAVE_VALID |=> !WAVE_VALID [*8])
        else $error("waveform valid too long");
    swap_acc_a: assert property (SAMPLE_VALID && wav_ff[5] |=>
        LINE_ACTIVE_ENERGY == $past(LINE_ACTIVE_ENERGY) + $past(LINE_REACTIVE_INC))
        else $error("swap accumulation wrong");
    act_off_a: assert property (!SAMPLE_VALID || sel3 == 0 |=> $stable(ACTIVE_ENERGY))
        else $error("active energy moved");
    neg_armed_a: assert property (SAMPLE_VALID |=> (NEG_POWER & ~$past(sel3)) == 0)
        else $error("negative flag not armed");
    irq_mask_a: assert property (WAVE_VALID && mask_ff |=> IRQ)
        else $error("interrupt missing");
    cover property (WAVE_VALID);
    cover property (SAMPLE_VALID && wav_ff[5]);
    cover property (PSLVERR);
endmodule
`default_nettype wire

// file: verif/energy_mode_bank_tb.sv
// Self-checking bench for the mode register bank.
// Assumes the checker file is compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module energy_mode_bank_tb;
    logic CLK_SYS = 1'h0;
    logic RST = 1'h1;
    logic PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0, SAMPLE_VALID = 1'h0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, WAVE_VALID, IRQ;
    logic signed [15:0] VA, VB, VC, IA, IB, IC, WAVE_SAMPLE;
    logic signed [32:0] LINE_REACTIVE_INC = 33'h0, LINE_APPARENT_INC = 33'h0;
    logic signed [47:0] ACTIVE_ENERGY, LINE_ACTIVE_ENERGY, LINE_APPARENT_ENERGY;
    logic [2:0] NEG_POWER;
    logic signed [15:0] src [6];
    longint acc_a = 0, acc_l = 0, acc_p = 0;
    int fail_count = 0, check_count = 0, i, n;
    logic bad;
    logic [7:0] w;
    always #20 CLK_SYS = ~CLK_SYS;
    energy_mode_bank u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID), .VA(VA), .VB(VB), .VC(VC), .IA(IA),
        .IB(IB), .IC(IC), .LINE_REACTIVE_INC(LINE_REACTIVE_INC),
        .LINE_APPARENT_INC(LINE_APPARENT_INC), .WAVE_SAMPLE(WAVE_SAMPLE),
        .WAVE_VALID(WAVE_VALID), .ACTIVE_ENERGY(ACTIVE_ENERGY),
        .LINE_ACTIVE_ENERGY(LINE_ACTIVE_ENERGY), .LINE_APPARENT_ENERGY(LINE_APPARENT_ENERGY),
        .NEG_POWER(NEG_POWER), .IRQ(IRQ));
    ////////////////////////////////////////////////////////////////////////
    task results();
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task apb(input logic wt, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int k;
        begin
            @(posedge CLK_SYS);
            PSEL <= 1'h1;
            PWRITE <= wt;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CLK_SYS);
            PENABLE <= 1'h1;
            k = 0;
            do begin
                @(posedge CLK_SYS);
                k++;
            end while (PREADY !== 1'h1 && k < 20);
            q = PRDATA;
            e = PSLVERR;
            PSEL <= 1'h0;
            PENABLE <= 1'h0;
            if (k >= 20) begin
                fail_count++;
                results();
            end
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'h1, a, d, q, e);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        begin
            apb(1'h0, a, 32'h0, q, e);
            `CHK("rdata", x, q)
            `CHK("slverr", xe, e)
        end
    endtask
    task wait_wave(output int k);
        begin
            k = 0;
            do begin
                @(posedge CLK_SYS);
                k++;
            end while (WAVE_VALID !== 1'h1 && k < 4000);
            if (k >= 4000) begin
                fail_count++;
                results();
            end
        end
    endtask
    // One sample through the reference energy model
    task smp(input logic [7:0] m, input logic sw);
        longint s [6];
        longint a, b, c, pa, pl, r, p;
        logic [2:0] ng;
        logic t;
        begin
            for (int j = 0; j < 6; j++)
                s[j] = $signed(16'($urandom));
            r = $signed(16'($urandom));
            p = $signed(16'($urandom));
            t = m[7:6] == 2'h1 || m[7:6] == 2'h2;
            a = s[0] * (s[3] - (t ? s[4] : 0));
            b = t ? 0 : s[1] * s[4];
            c = s[2] * (s[5] - (m[7:6] == 2'h1 ? s[4] : 0));
            pa = (m[5] ? a : 0) + (m[4] ? b : 0) + (m[3] ? c : 0);
            pl = (m[2] ? a : 0) + (m[1] ? b : 0) + (m[0] ? c : 0);
            ng = {m[3] && c < 0, m[4] && b < 0, m[5] && a < 0};
            acc_a += pa;
            acc_l += sw ? r : pl;
            acc_p += sw ? pl : p;
            @(posedge CLK_SYS);
            {VA, VB, VC} <= {s[0][15:0], s[1][15:0], s[2][15:0]};
            {IA, IB, IC} <= {s[3][15:0], s[4][15:0], s[5][15:0]};
            LINE_REACTIVE_INC <= r[32:0];
            LINE_APPARENT_INC <= p[32:0];
            SAMPLE_VALID <= 1'h1;
            @(posedge CLK_SYS);
            SAMPLE_VALID <= 1'h0;
            @(negedge CLK_SYS);
            `CHK("active", acc_a[47:0], ACTIVE_ENERGY)
            `CHK("line", acc_l[47:0], LINE_ACTIVE_ENERGY)
            `CHK("apparent", acc_p[47:0], LINE_APPARENT_ENERGY)
            `CHK("neg", ng, NEG_POWER)
            rd(8'h40, {17'h0, ng, 12'h000}, 1'h0);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8D64));
        for (i = 0; i < 6; i++)
            src[i] = 16'($urandom);
        {VA, VB, VC, IA, IB, IC} = {src[0], src[1], src[2], src[3], src[4], src[5]};
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'h0;
        rd(8'h30, 32'h0, 1'h0);
        rd(8'h34, 32'h3F, 1'h0);
        rd(8'hFC, 32'h0, 1'h1);
        wr(8'h34, 32'h1AA);
        rd(8'h34, 32'hAA, 1'h0);
        $display("register test done");
        for (i = 0; i < 6; i++) begin
            wr(8'h30, i);
            wait_wave(n);
            wait_wave(n);
            `CHK("wave", src[i], WAVE_SAMPLE)
        end
        for (i = 6; i < 8; i++) begin
            wr(8'h30, i);
            @(posedge CLK_SYS);
            bad = 1'h0;
            repeat (800) begin
                @(negedge CLK_SYS);
                if (WAVE_VALID !== 1'h0 || WAVE_SAMPLE !== 16'h0)
                    bad = 1'h1;
            end
            `CHK("reserved", 1'h0, bad)
        end
        $display("source test done");
        for (i = 0; i < 4; i++) begin
            wr(8'h30, i << 3);
            repeat (3) wait_wave(n);
            `CHK("period", 384 << i, n)
        end
        $display("rate test done");
        for (i = 0; i < 12; i++) begin
            w = {i[1:0], (i == 0) ? 6'h00 : 6'($urandom)};
            wr(8'h34, w);
            smp(w, 1'h0);
        end
        wr(8'h30, 32'h20);
        smp(w, 1'h1);
        smp(w, 1'h1);
        wr(8'h30, 32'h0);
        $display("energy test done");
        wr(8'h44, 32'hF);
        wr(8'h48, 32'h1);
        wait_wave(n);
        @(negedge CLK_SYS);
        `CHK("irq", 1'h1, IRQ)
        rd(8'h44, 32'h1, 1'h0);
        wr(8'h44, 32'h1);
        repeat (2) @(negedge CLK_SYS);
        `CHK("irq clear", 1'h0, IRQ)
        wr(8'h48, 32'h0);
        wait_wave(n);
        repeat (2) @(negedge CLK_SYS);
        `CHK("irq masked", 1'h0, IRQ)
        rd(8'h44, 32'h1, 1'h0);
        $display("interrupt test done");
        results();
    end
endmodule
bind energy_mode_bank energy_mode_checker #(.SMP_W(SMP_W), .ACC_W(ACC_W)) u_chk (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SAMPLE_VALID(SAMPLE_VALID), .LINE_REACTIVE_INC(LINE_REACTIVE_INC),
    .WAVE_SAMPLE(WAVE_SAMPLE), .WAVE_VALID(WAVE_VALID), .ACTIVE_ENERGY(ACTIVE_ENERGY),
    .LINE_ACTIVE_ENERGY(LINE_ACTIVE_ENERGY), .NEG_POWER(NEG_POWER), .IRQ(IRQ));
`default_nettype wire
